//--- rtl/pdt_gap_ctrl.sv
// Deadtime control for two complementary gate-drive outputs, with fixed and adaptive modes.
// Assumes pwm_in and the adapt_* pulses come from logic on sys_clk; write_protect is a pin.
// Behaviour
// - High-to-low gap from upper byte, signed ns
// - Low-to-high gap from lower byte, signed ns
// - Positive gap keeps both drives off between
// - Negative gap overlaps drives by its magnitude
// - Gap write then mode write sets maximums
// - Frozen transition applies programmed gap exactly
// - Gap values reset to 1010h
// - Bit 15 zero adaptive, one frozen (H-L)
// - Bit 7 zero adaptive, one frozen (L-H)
// - Bits 14:8 set adaptive H-L minimum
// - Bits 6:0 set adaptive L-H minimum
// - Mode register resets to 8888h, frozen
// - Gap values read/write, write-protectable
`timescale 1ns/100ps
`default_nettype none
module pdt_gap_ctrl (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_ack,
  output logic cmd_refused,
  input wire logic write_protect,
  input wire logic pwm_in,
  input wire logic adapt_up_hl,
  input wire logic adapt_dn_hl,
  input wire logic adapt_up_lh,
  input wire logic adapt_dn_lh,
  output logic gate_hi,
  output logic gate_lo,
  output logic [7:0] applied_hl,
  output logic [7:0] applied_lh
);
  import pdt_pkg::*;

  typedef struct packed {
    logic [15:0] values;
    logic [15:0] mode;
    logic [7:0] max_hl;
    logic [7:0] max_lh;
    logic [7:0] act_hl;
    logic [7:0] act_lh;
    logic last_gap_wr;
    logic wp_s1;
    logic wp_s2;
    logic [PDT_HIST_LEN-1:0] hist;
    logic [15:0] rdata;
    logic ack;
    logic refused;
    logic hi;
    logic lo;
  } pdt_state_s;

  pdt_state_s st_q;
  pdt_state_s st_d;

  // Magnitude in ns to whole clock cycles, rounded up so a gap is never shortened
  function automatic logic [5:0] pdt_cyc(input logic [7:0] mag);
    logic [8:0] sum;
    sum = {1'b0, mag} + 9'(PDT_CLK_PERIOD_NS - 1);
    pdt_cyc = sum[7:2];
  endfunction : pdt_cyc

  function automatic logic [7:0] pdt_abs(input logic [7:0] v);
    pdt_abs = v[7] ? 8'(-v) : v;
  endfunction : pdt_abs

  // Minimum field is even ns; the lowest bit is dropped for 2 ns resolution
  function automatic logic [7:0] pdt_min_ns(input logic [6:0] f);
    pdt_min_ns = {1'b0, f[6:1], 1'b0};
  endfunction : pdt_min_ns

  // Signed clamp; the minimum wins if a maximum was set below it
  function automatic logic [7:0] pdt_clamp(
    input logic [7:0] v,
    input logic [7:0] lo_v,
    input logic [7:0] hi_v
  );
    logic [7:0] r;
    r = v;
    if ($signed(r) > $signed(hi_v)) begin
      r = hi_v;
    end
    if ($signed(r) < $signed(lo_v)) begin
      r = lo_v;
    end
    pdt_clamp = r;
  endfunction : pdt_clamp

  // One adaptive step of 2 ns up or down, then clamped
  function automatic logic [7:0] pdt_step(
    input logic [7:0] v,
    input logic up,
    input logic dn,
    input logic [7:0] lo_v,
    input logic [7:0] hi_v
  );
    logic [7:0] r;
    r = v;
    // Guard band keeps a step from wrapping the signed range
    if (up && !dn && $signed(v) < $signed(8'h78)) begin
      r = v + 8'(PDT_STEP_NS);
    end else if (dn && !up && $signed(v) > $signed(8'h88)) begin
      r = v - 8'(PDT_STEP_NS);
    end
    pdt_step = pdt_clamp(r, lo_v, hi_v);
  endfunction : pdt_step

  // Delayed edge pair: rise after a cycles, fall after b cycles
  function automatic logic pdt_pulse(
    input logic [PDT_HIST_LEN-1:0] h,
    input logic [5:0] a,
    input logic [5:0] b
  );
    logic r;
    if (a >= b) begin
      r = h[a] & h[b];
    end else begin
      r = h[a] | h[b];
    end
    pdt_pulse = r;
  endfunction : pdt_pulse

  function automatic logic pdt_hit_values(input logic [7:0] code);
    pdt_hit_values = (code == PDT_CMD_GAP_VALUES);
  endfunction : pdt_hit_values

  function automatic logic pdt_hit_mode(input logic [7:0] code);
    pdt_hit_mode = (code == PDT_CMD_GAP_MODE);
  endfunction : pdt_hit_mode

  // Cycles the incoming drive waits; a negative gap gives no wait
  function automatic logic [5:0] pdt_wait_cyc(input logic [7:0] gap);
    logic [5:0] r;
    r = 6'h00;
    if (!gap[7]) begin
      r = pdt_cyc(gap);
    end
    pdt_wait_cyc = r;
  endfunction : pdt_wait_cyc

  // Cycles the outgoing drive is held on; only a negative gap overlaps
  function automatic logic [5:0] pdt_hold_cyc(input logic [7:0] gap);
    logic [5:0] r;
    r = 6'h00;
    if (gap[7]) begin
      r = pdt_cyc(pdt_abs(gap));
    end
    pdt_hold_cyc = r;
  endfunction : pdt_hold_cyc

  // Frozen applies the programmed gap; adaptive steps from the gap in use
  function automatic logic [7:0] pdt_next_gap(
    input logic frozen,
    input logic [7:0] prog,
    input logic [7:0] cur,
    input logic up,
    input logic dn,
    input logic [6:0] min_f,
    input logic [7:0] max_v
  );
    logic [7:0] r;
    if (frozen) begin
      r = prog;
    end else begin
      r = pdt_step(cur, up, dn, pdt_min_ns(min_f), max_v);
    end
    pdt_next_gap = r;
  endfunction : pdt_next_gap

  logic [7:0] gap_hl;
  logic [7:0] gap_lh;
  logic [5:0] hi_rise;
  logic [5:0] hi_fall;
  logic [5:0] lo_rise;
  logic [5:0] lo_fall;
  logic wr_ok;
  logic hit_values;
  logic hit_mode;

  always_comb begin
    st_d = st_q;
    st_d.wp_s1 = write_protect;
    st_d.wp_s2 = st_q.wp_s1;
    st_d.ack = 1'b0;
    st_d.refused = 1'b0;
    hit_values = pdt_hit_values(cmd_code);
    hit_mode = pdt_hit_mode(cmd_code);
    wr_ok = cmd_valid && cmd_write && !st_q.wp_s2;
    // Command port; only a known code is acknowledged, so ack and refusal never meet
    if (cmd_valid) begin
      if (cmd_write) begin
        if (st_q.wp_s2) begin
          st_d.refused = 1'b1;
        end else begin
          unique case (cmd_code)
            PDT_CMD_GAP_VALUES: begin
              st_d.values = cmd_wdata;
              st_d.ack = 1'b1;
            end
            PDT_CMD_GAP_MODE: begin
              st_d.mode = cmd_wdata;
              st_d.ack = 1'b1;
            end
            default: st_d.refused = 1'b1;
          endcase
        end
      end else begin
        unique case (cmd_code)
          PDT_CMD_GAP_VALUES: begin
            st_d.rdata = st_q.values;
            st_d.ack = 1'b1;
          end
          PDT_CMD_GAP_MODE: begin
            st_d.rdata = st_q.mode;
            st_d.ack = 1'b1;
          end
          default: begin
            st_d.rdata = 16'h0000;
            st_d.refused = 1'b1;
          end
        endcase
      end
    end
    // Any command other than a gap write, save a write refused by protection, breaks the gap-then-mode pairing
    if (wr_ok && hit_values) begin
      st_d.last_gap_wr = 1'b1;
    end else if (cmd_valid && !(cmd_write && st_q.wp_s2)) begin
      st_d.last_gap_wr = 1'b0;
    end
    if (wr_ok && hit_mode && st_q.last_gap_wr) begin
      st_d.max_hl = st_q.values[PDT_HL_LSB +: 8];
      st_d.max_lh = st_q.values[PDT_LH_LSB +: 8];
    end

    // Applied gaps; a frozen transition follows the programmed value one cycle later
    st_d.act_hl = pdt_next_gap(
      st_q.mode[PDT_HL_FREEZE_BIT],
      st_q.values[PDT_HL_LSB +: 8],
      st_q.act_hl,
      adapt_up_hl,
      adapt_dn_hl,
      st_q.mode[PDT_HL_LSB +: PDT_MIN_W],
      st_q.max_hl
    );
    st_d.act_lh = pdt_next_gap(
      st_q.mode[PDT_LH_FREEZE_BIT],
      st_q.values[PDT_LH_LSB +: 8],
      st_q.act_lh,
      adapt_up_lh,
      adapt_dn_lh,
      st_q.mode[PDT_LH_LSB +: PDT_MIN_W],
      st_q.max_lh
    );

    // Edge timing from pwm history
    gap_hl = st_q.act_hl;
    gap_lh = st_q.act_lh;
    hi_rise = pdt_wait_cyc(gap_lh);
    lo_fall = pdt_hold_cyc(gap_lh);
    lo_rise = pdt_wait_cyc(gap_hl);
    hi_fall = pdt_hold_cyc(gap_hl);
    st_d.hist = {st_q.hist[PDT_HIST_LEN-2:0], pwm_in};
    st_d.hi = pdt_pulse(st_d.hist, hi_rise, hi_fall);
    st_d.lo = pdt_pulse(~st_d.hist, lo_rise, lo_fall);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q.last_gap_wr <= 1'b0;
      st_q.wp_s1 <= 1'b0;
      st_q.wp_s2 <= 1'b0;
      st_q.hist <= '0;
      st_q.rdata <= 16'h0000;
      st_q.ack <= 1'b0;
      st_q.refused <= 1'b0;
      st_q.hi <= 1'b0;
      st_q.lo <= 1'b0;
      st_q.values <= PDT_GAP_VALUES_RST;
      st_q.mode <= PDT_GAP_MODE_RST;
      st_q.max_hl <= PDT_GAP_VALUES_RST[15:8];
      st_q.max_lh <= PDT_GAP_VALUES_RST[7:0];
      st_q.act_hl <= PDT_GAP_VALUES_RST[15:8];
      st_q.act_lh <= PDT_GAP_VALUES_RST[7:0];
    end else begin
      st_q <= st_d;
    end
  end

  assign cmd_rdata = st_q.rdata;
  assign cmd_ack = st_q.ack;
  assign cmd_refused = st_q.refused;
  assign gate_hi = st_q.hi;
  assign gate_lo = st_q.lo;
  assign applied_hl = st_q.act_hl;
  assign applied_lh = st_q.act_lh;
endmodule : pdt_gap_ctrl
`default_nettype wire

//--- rtl/pdt_pkg.sv
// Package for the deadtime block: command codes, field layout, reset values and timing constants.
// Assumes a command port driven by a management bus front end on the same clock.
package pdt_pkg;
  localparam logic [7:0] PDT_CMD_GAP_VALUES = 8'hDD;
  localparam logic [7:0] PDT_CMD_GAP_MODE = 8'hDE;
  localparam logic [15:0] PDT_GAP_VALUES_RST = 16'h1010;
  localparam logic [15:0] PDT_GAP_MODE_RST = 16'h8888;
  localparam int PDT_HL_LSB = 8;
  localparam int PDT_LH_LSB = 0;
  localparam int PDT_HL_FREEZE_BIT = 15;
  localparam int PDT_LH_FREEZE_BIT = 7;
  localparam int PDT_MIN_W = 7;
  localparam int PDT_CLK_PERIOD_NS = 4;
  localparam int PDT_STEP_NS = 2;
  localparam int PDT_HIST_LEN = 33;
endpackage : pdt_pkg

//--- sim/pdt_gap_ctrl_assertions.sv
// Checker for the deadtime block, bound to its ports.
// Assumes pwm_in holds steady well past the gap spread.
`timescale 1ns/100ps
`default_nettype none
module pdt_gap_ctrl_chk (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_ack,
  input wire logic cmd_refused,
  input wire logic write_protect,
  input wire logic pwm_in,
  input wire logic gate_hi,
  input wire logic gate_lo,
  input wire logic [7:0] applied_hl,
  input wire logic [7:0] applied_lh
);
  import pdt_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic known = cmd_code == PDT_CMD_GAP_VALUES || cmd_code == PDT_CMD_GAP_MODE;
  cmd_answer_a: assert property (cmd_valid |=> cmd_ack ^ cmd_refused) else $error("no single answer");
  unknown_refuse_a: assert property (cmd_valid && !known |=> cmd_refused) else $error("unknown taken");
  prot_refuse_a: assert property (
    cmd_valid && cmd_write && write_protect && $past(write_protect) && $past(write_protect, 2) |=> cmd_refused)
    else $error("protected write taken");
  rdata_hold_a: assert property (
    !$past(cmd_valid && !cmd_write) |-> $stable(cmd_rdata)) else $error("read data moved");
  pos_gap_a: assert property (
    $signed(applied_hl) > 0 && $signed(applied_lh) > 0 |-> !(gate_hi && gate_lo)) else $error("drives overlap");
  rise_gap_a: assert property (
    $rose(pwm_in) && applied_lh == 8'h10 |-> (!gate_hi) [*5] ##[0:1] gate_hi) else $error("rise gap wrong");
  fall_gap_a: assert property (
    $fell(pwm_in) && applied_hl == 8'h10 |-> (!gate_lo) [*5] ##[0:1] gate_lo) else $error("fall gap wrong");
  neg_overlap_a: assert property (
    $rose(pwm_in) && applied_lh == 8'hF8 |-> ##2 (gate_hi && gate_lo) ##[1:2] !gate_lo) else $error("overlap wrong");
  cover property (cmd_refused);
  cover property ($rose(gate_hi));
  cover property (gate_hi && gate_lo);
endmodule : pdt_gap_ctrl_chk
bind pdt_gap_ctrl pdt_gap_ctrl_chk i_chk (.*);
`default_nettype wire

//--- sim/pdt_stage_model.sv
// Power-stage model: counts cycles in which both drives conduct.
// Assumes registered gate drives on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module pdt_stage_model (
  input wire logic sys_clk,
  input wire logic gate_hi,
  input wire logic gate_lo,
  output logic [7:0] overlap_cnt
);
  initial overlap_cnt = 8'h00;
  always @(posedge sys_clk) if (gate_hi && gate_lo) overlap_cnt <= overlap_cnt + 8'h01;
endmodule : pdt_stage_model
`default_nettype wire

//--- sim/tb_pwm_deadtime_control.sv
// Testbench for the deadtime block: commands, protection, gate timing, adaptive clamps.
// Assumes the checker binds itself to the design.
`timescale 1ns/100ps
`default_nettype none
module tb_pwm_deadtime_control;
  import pdt_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0, write_protect = 1'b0, pwm_in = 1'b0;
  logic [7:0] cmd_code = 8'h00, applied_hl, applied_lh, overlap_cnt;
  logic [15:0] cmd_wdata = 16'h0000, cmd_rdata;
  logic [3:0] adapt = 4'h0;
  logic cmd_ack, cmd_refused, gate_hi, gate_lo;
  int error_cnt = 0, samples_checked = 0;
  initial forever #2 sys_clk = ~sys_clk;
  pdt_gap_ctrl i_dut (.*, .adapt_up_hl(adapt[3]), .adapt_dn_hl(adapt[2]), .adapt_up_lh(adapt[1]), .adapt_dn_lh(adapt[0]));
  pdt_stage_model i_stage (.sys_clk(sys_clk), .gate_hi(gate_hi), .gate_lo(gate_lo), .overlap_cnt(overlap_cnt));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd, input logic rf, input logic [15:0] rd);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = wd;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    chk({14'h0000, cmd_ack, cmd_refused}, {14'h0000, !rf, rf});
    if (!wr) chk(cmd_rdata, rd);
  endtask : cmd
  task automatic pwm_pulse();
    repeat (2) begin
      @(negedge sys_clk);
      pwm_in = ~pwm_in;
      repeat (20) @(negedge sys_clk);
    end
  endtask : pwm_pulse
  // Forty 2 ns steps cover 80 ns, more than any span set here, so each run ends pinned at a clamp
  task automatic step(input logic [3:0] m);
    repeat (40) begin
      @(negedge sys_clk);
      adapt = m;
      @(negedge sys_clk);
      adapt = 4'h0;
    end
    repeat (2) @(negedge sys_clk);
  endtask : step
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    #40000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    reset_n = 1'b1;
    cmd(1'b0, PDT_CMD_GAP_VALUES, 16'h0000, 1'b0, PDT_GAP_VALUES_RST);
    cmd(1'b0, PDT_CMD_GAP_MODE, 16'h0000, 1'b0, PDT_GAP_MODE_RST);
    cmd(1'b0, 8'hDC, 16'h0000, 1'b1, 16'h0000);
    chk({applied_hl, applied_lh}, 16'h1010);
    pwm_pulse();
    chk({8'h00, overlap_cnt}, 16'h0000);
    $display("test defaults done");
    cmd(1'b1, PDT_CMD_GAP_VALUES, 16'h10F8, 1'b0, 16'h0000);
    repeat (2) @(negedge sys_clk);
    chk({applied_hl, applied_lh}, 16'h10F8);
    pwm_pulse();
    chk({8'h00, overlap_cnt}, 16'h0002);
    $display("test overlap done");
    write_protect = 1'b1;
    repeat (3) @(negedge sys_clk);
    cmd(1'b1, PDT_CMD_GAP_VALUES, 16'h3C3C, 1'b1, 16'h0000);
    cmd(1'b0, PDT_CMD_GAP_VALUES, 16'h0000, 1'b0, 16'h10F8);
    @(negedge sys_clk);
    write_protect = 1'b0;
    repeat (3) @(negedge sys_clk);
    $display("test protect done");
    cmd(1'b1, PDT_CMD_GAP_VALUES, 16'h2020, 1'b0, 16'h0000);
    cmd(1'b1, PDT_CMD_GAP_MODE, 16'h0404, 1'b0, 16'h0000);
    step(4'h5);
    chk({applied_hl, applied_lh}, 16'h0404);
    step(4'hA);
    chk({applied_hl, applied_lh}, 16'h2020);
    cmd(1'b1, PDT_CMD_GAP_VALUES, 16'h3030, 1'b0, 16'h0000);
    cmd(1'b0, PDT_CMD_GAP_MODE, 16'h0000, 1'b0, 16'h0404);
    cmd(1'b1, PDT_CMD_GAP_MODE, 16'h0404, 1'b0, 16'h0000);
    step(4'hA);
    chk({applied_hl, applied_lh}, 16'h2020);
    cmd(1'b1, PDT_CMD_GAP_MODE, 16'h8404, 1'b0, 16'h0000);
    step(4'h5);
    chk({applied_hl, applied_lh}, 16'h3004);
    $display("test adaptive done");
    give_verdict();
  end
endmodule : tb_pwm_deadtime_control
`default_nettype wire
